// *** shared/vfd_port_pkg.sv ***
package vfd_port_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int TEXT_DEPTH = 80;
  localparam int LINE_LEN = 40;
  localparam int GLYPH_DEPTH = 64;
  localparam int DIGITS = 24;
  localparam int FIFO_DEPTH = 32;
  localparam int POS_W = 5;
  localparam int CODE_W = 1 + POS_W + DATA_W;
  // status byte layout
  localparam int BUSY_BIT = 7;
  localparam logic BUSY_VALUE = 1'b0;
  // text address map
  localparam logic [6:0] ONE_LINE_LAST = 7'h4F;
  localparam logic [6:0] LINE1_LAST = 7'h27;
  localparam logic [6:0] LINE2_FIRST = 7'h40;
  localparam logic [6:0] LINE2_LAST = 7'h67;
  localparam logic [6:0] LINE2_INDEX = 7'h28;
  localparam logic [6:0] OFFSET_LAST = 7'h4F;
  localparam logic [6:0] LINE_LEN_7 = 7'h28;
  localparam logic [6:0] TEXT_DEPTH_7 = 7'h50;
  // instruction decode
  localparam int TEXT_ADDR_BIT = 7;
  localparam int GLYPH_ADDR_BIT = 6;
  localparam int FUNC_BIT = 5;
  localparam int FUNC_WIDTH_BIT = 4;
  localparam int FUNC_LINES_BIT = 3;
  localparam int SHIFT_BIT = 4;
  localparam int SHIFT_DISPLAY_BIT = 3;
  localparam int SHIFT_RIGHT_BIT = 2;
  localparam logic [7:0] HOME_CODE = 8'h02;
  // reset values
  localparam logic WIDTH8_RESET = 1'b1;
  localparam logic TWO_LINE_RESET = 1'b0;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage : vfd_port_pkg

// *** src/code_fifo.sv ***
`timescale 1ns/1ps
module code_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_sync_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != DEPTH[PTR_W:0]);
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : code_fifo

// *** src/vfd_host_port.sv ***
// Function
// (R01) link style pin: low serial, high parallel; parallel strobes ignored when low
// (R02) parallel transfers accepted on a 4-bit or an 8-bit data bus
// (R03) host ties pins unused in the chosen link style to fixed levels
// (R04) two 8-bit registers: instruction register and transfer data register
// (R05) instruction register is write-only; status read never returns it
// (R06) select-low write loads instruction register and runs its operation
// (R07) select-low read returns busy bit on bit 7, address pointer below
// (R08) busy bit always reads low
// (R09) select-high write passes data byte into selected text or glyph RAM
// (R10) select-high read returns selected RAM byte through transfer data register; code drives the pins from read_byte, transfer_data_reg only copies it
// (R11) address instruction copies its address field into the address pointer
// (R12) address instruction also picks text RAM or glyph RAM as target
// (R13) address pointer increments by one after each data write or read
// (R14) text RAM holds 80 eight-bit character codes
// (R15) text locations off the display act as ordinary read/write storage
// (R16) text address held in address pointer as 7-bit value
// (R17) one-line mode starts at address 00; 24 positions show 00 to 17
// (R18) one-line shift offsets start circularly over 80; left 01, right 4F
// (R19) two-line mode: line one 00 to 27, line two 40 to 67
// (R20) two-line shift wraps each line separately; right shift shows 27, 67
// (R21) a 40-character two-line system adds a 16-output grid extension driver
// (R22) 4-bit mode moves each byte as two nibbles on pins 7:4, high first
`timescale 1ns/1ps
module vfd_host_port #(
  parameter int DIGIT_COUNT = vfd_port_pkg::DIGITS,
  parameter int CODE_FIFO_DEPTH = vfd_port_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link straps
  input wire logic link_style_select,
  input wire logic host_bus_style_select,
  // host strobes
  input wire logic chip_select_n,
  input wire logic register_select_line,
  input wire logic enable_or_read_n,
  input wire logic rw_or_write_n,
  // parallel data pins
  input wire logic [7:0] parallel_data_pins_in,
  output logic [7:0] parallel_data_pins_out,
  output logic [7:0] parallel_data_pins_oe_n,
  // character code stream to the drive logic
  output logic code_valid,
  input wire logic code_ready,
  output logic [7:0] code_char,
  output logic [4:0] code_position,
  output logic code_line,
  // mode status
  output logic bus_width_8,
  output logic two_line_mode
);
  logic [1:0] rst_pipe_reg;
  logic rst_sync_n;

  logic [7:0] instruction_reg;
  logic [7:0] transfer_data_reg;
  logic [6:0] address_pointer;
  logic glyph_target_reg;
  logic width8_reg;
  logic two_line_reg;
  logic [6:0] offset_reg;

  logic strobe_now;
  logic read_now;
  logic strobe_reg;
  logic read_reg;
  logic select_reg;
  logic [7:0] din_reg;
  logic start;
  logic finish;
  logic nibble_low_reg;
  logic [3:0] high_nibble_reg;
  logic [7:0] read_byte_reg;
  logic [7:0] write_byte;
  logic [7:0] read_byte;
  logic [7:0] fetch_byte;
  logic byte_done;
  logic write_commit;
  logic read_commit;
  logic [7:0] out_reg;
  logic [7:0] oe_n_reg;

  logic [7:0] text_ram [0:vfd_port_pkg::TEXT_DEPTH-1];
  logic [7:0] glyph_ram [0:vfd_port_pkg::GLYPH_DEPTH-1];
  logic [6:0] text_index;
  logic text_hit;

  logic [4:0] pos_reg;
  logic line_reg;
  logic [6:0] scan_index;
  logic [6:0] off40;
  logic [6:0] sum;
  logic fifo_in_ready;
  logic [vfd_port_pkg::CODE_W-1:0] fifo_out_data;
  logic fifo_out_valid;

  // reset release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_reg[1];

  // access detection; 68-style uses an active-high enable, 80-style two low strobes
  always_comb begin
    if (host_bus_style_select) begin
      strobe_now = enable_or_read_n;
      read_now = rw_or_write_n;
    end else begin
      strobe_now = !enable_or_read_n || !rw_or_write_n;
      read_now = !enable_or_read_n;
    end
    strobe_now = strobe_now && !chip_select_n && link_style_select; // (R01)
  end

  assign start = strobe_now && !strobe_reg;
  assign finish = strobe_reg && !strobe_now;
  assign byte_done = width8_reg || nibble_low_reg; // (R02)
  // second nibble completes the byte with the earlier high half
  assign write_byte = width8_reg ? din_reg : {high_nibble_reg, din_reg[7:4]}; // (R22)
  assign write_commit = finish && !read_reg && byte_done; // (R06)
  assign read_commit = finish && read_reg && byte_done;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      strobe_reg <= 1'b0;
      read_reg <= 1'b0;
      select_reg <= 1'b0;
      din_reg <= vfd_port_pkg::BYTE_RESET;
    end else begin
      strobe_reg <= strobe_now;
      if (start) begin
        read_reg <= read_now;
        select_reg <= register_select_line;
      end
      // write data is the level seen on the last active cycle
      if (strobe_now) begin
        din_reg <= parallel_data_pins_in;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      nibble_low_reg <= 1'b0;
      high_nibble_reg <= 4'h0;
    end else if (width8_reg) begin
      nibble_low_reg <= 1'b0;
    end else if (finish) begin
      nibble_low_reg <= !nibble_low_reg; // (R22)
      if (!nibble_low_reg) begin
        high_nibble_reg <= din_reg[7:4];
      end
    end
  end

  // text address to RAM index; line two packs directly after line one
  always_comb begin
    text_hit = 1'b0;
    text_index = address_pointer;
    if (two_line_reg) begin
      if (address_pointer <= vfd_port_pkg::LINE1_LAST) begin // (R19)
        text_hit = 1'b1;
      end else if (address_pointer >= vfd_port_pkg::LINE2_FIRST
                   && address_pointer <= vfd_port_pkg::LINE2_LAST) begin
        text_hit = 1'b1;
        text_index = address_pointer - vfd_port_pkg::LINE2_FIRST
                     + vfd_port_pkg::LINE2_INDEX;
      end
    end else begin
      text_hit = (address_pointer <= vfd_port_pkg::ONE_LINE_LAST); // (R16)
    end
  end

  always_comb begin
    if (glyph_target_reg) begin
      fetch_byte = glyph_ram[address_pointer[5:0]];
    end else if (text_hit) begin
      fetch_byte = text_ram[text_index]; // (R15)
    end else begin
      fetch_byte = vfd_port_pkg::BYTE_RESET;
    end
    if (register_select_line) begin
      read_byte = fetch_byte; // (R10)
    end else begin
      read_byte = {vfd_port_pkg::BUSY_VALUE, address_pointer}; // (R07) (R08) (R05)
    end
  end

  // memories; writes to unmapped text addresses are dropped
  always_ff @(posedge clock) begin
    if (write_commit && select_reg) begin
      if (glyph_target_reg) begin
        glyph_ram[address_pointer[5:0]] <= write_byte; // (R09)
      end else if (text_hit) begin
        text_ram[text_index] <= write_byte; // (R09) (R14)
      end
    end
  end

  // read path: the byte is frozen at the first nibble so both halves match
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      read_byte_reg <= vfd_port_pkg::BYTE_RESET;
      out_reg <= vfd_port_pkg::BYTE_RESET;
      oe_n_reg <= 8'hFF;
    end else begin
      if (start && read_now) begin
        if (width8_reg) begin
          read_byte_reg <= read_byte;
          out_reg <= read_byte;
        end else if (!nibble_low_reg) begin
          read_byte_reg <= read_byte;
          out_reg <= {read_byte[7:4], 4'h0}; // (R22)
        end else begin
          out_reg <= {read_byte_reg[3:0], 4'h0};
        end
      end
      if (strobe_now && read_now) begin
        oe_n_reg <= width8_reg ? 8'h00 : 8'h0F;
      end else begin
        oe_n_reg <= 8'hFF;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      transfer_data_reg <= vfd_port_pkg::BYTE_RESET;
    end else if (write_commit && select_reg) begin
      transfer_data_reg <= write_byte; // (R04)
    end else if (start && read_now && register_select_line && byte_done) begin
      transfer_data_reg <= fetch_byte; // (R10)
    end
  end

  // next address after a data access, wrapping inside the active space
  function automatic logic [6:0] next_address(input logic [6:0] a, input logic glyph,
                                               input logic two);
    logic [6:0] n;
    n = a + 7'h01;
    if (glyph) begin
      n = {1'b0, n[5:0]};
    end else if (two) begin
      if (a == vfd_port_pkg::LINE1_LAST) begin
        n = vfd_port_pkg::LINE2_FIRST;
      end else if (a >= vfd_port_pkg::LINE2_LAST) begin
        n = vfd_port_pkg::ADDR_RESET;
      end
    end else if (a >= vfd_port_pkg::ONE_LINE_LAST) begin
      n = vfd_port_pkg::ADDR_RESET;
    end
    return n;
  endfunction : next_address

  // instruction register and the operations it starts
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      instruction_reg <= vfd_port_pkg::BYTE_RESET;
      address_pointer <= vfd_port_pkg::ADDR_RESET;
      glyph_target_reg <= 1'b0;
      width8_reg <= vfd_port_pkg::WIDTH8_RESET;
      two_line_reg <= vfd_port_pkg::TWO_LINE_RESET;
      offset_reg <= vfd_port_pkg::ADDR_RESET;
    end else if (write_commit && !select_reg) begin
      instruction_reg <= write_byte; // (R06)
      if (write_byte[vfd_port_pkg::TEXT_ADDR_BIT]) begin
        address_pointer <= write_byte[6:0]; // (R11) (R16)
        glyph_target_reg <= 1'b0; // (R12)
      end else if (write_byte[vfd_port_pkg::GLYPH_ADDR_BIT]) begin
        address_pointer <= {1'b0, write_byte[5:0]}; // (R11)
        glyph_target_reg <= 1'b1; // (R12)
      end else if (write_byte[vfd_port_pkg::FUNC_BIT]) begin
        width8_reg <= write_byte[vfd_port_pkg::FUNC_WIDTH_BIT]; // (R02)
        two_line_reg <= write_byte[vfd_port_pkg::FUNC_LINES_BIT];
      end else if (write_byte[vfd_port_pkg::SHIFT_BIT]) begin
        if (write_byte[vfd_port_pkg::SHIFT_DISPLAY_BIT]) begin
          if (write_byte[vfd_port_pkg::SHIFT_RIGHT_BIT]) begin
            offset_reg <= (offset_reg == 7'h00) ? vfd_port_pkg::OFFSET_LAST
                          : offset_reg - 7'h01; // (R18) (R20)
          end else begin
            offset_reg <= (offset_reg == vfd_port_pkg::OFFSET_LAST) ? 7'h00
                          : offset_reg + 7'h01; // (R18) (R20)
          end
        end
      end else if (write_byte[7:1] == vfd_port_pkg::HOME_CODE[7:1]) begin
        address_pointer <= vfd_port_pkg::ADDR_RESET;
        glyph_target_reg <= 1'b0;
        offset_reg <= vfd_port_pkg::ADDR_RESET;
      end
    end else if ((write_commit || read_commit) && select_reg) begin
      address_pointer <= next_address(address_pointer, glyph_target_reg,
                                      two_line_reg); // (R13)
    end
  end

  // display scan: position plus shift offset, wrapped per line in two-line mode
  always_comb begin
    off40 = offset_reg;
    if (off40 >= vfd_port_pkg::LINE_LEN_7) begin
      off40 = off40 - vfd_port_pkg::LINE_LEN_7;
    end
    if (two_line_reg) begin
      sum = {2'b00, pos_reg} + off40;
      if (sum >= vfd_port_pkg::LINE_LEN_7) begin
        sum = sum - vfd_port_pkg::LINE_LEN_7; // (R20)
      end
      scan_index = line_reg ? sum + vfd_port_pkg::LINE_LEN_7 : sum; // (R19)
    end else begin
      sum = {2'b00, pos_reg} + offset_reg; // (R17)
      if (sum >= vfd_port_pkg::TEXT_DEPTH_7) begin
        sum = sum - vfd_port_pkg::TEXT_DEPTH_7; // (R18)
      end
      scan_index = sum;
    end
  end

  // the scan stalls whenever the code queue is full
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pos_reg <= 5'h00;
      line_reg <= 1'b0;
    end else if (fifo_in_ready) begin
      if (pos_reg == 5'(DIGIT_COUNT - 1)) begin
        pos_reg <= 5'h00;
        line_reg <= two_line_reg && !line_reg;
      end else begin
        pos_reg <= pos_reg + 5'h01;
      end
    end
  end

  code_fifo #(
    .WIDTH(vfd_port_pkg::CODE_W),
    .DEPTH(CODE_FIFO_DEPTH)
  ) u_code_fifo (
    .clock(clock),
    .rst_sync_n(rst_sync_n),
    .in_valid(rst_sync_n),
    .in_ready(fifo_in_ready),
    .in_data({line_reg, pos_reg, text_ram[scan_index]}),
    .out_valid(fifo_out_valid),
    .out_ready(code_ready),
    .out_data(fifo_out_data)
  );

  assign code_valid = fifo_out_valid;
  assign code_line = fifo_out_data[vfd_port_pkg::CODE_W-1];
  assign code_position = fifo_out_data[vfd_port_pkg::CODE_W-2:vfd_port_pkg::DATA_W];
  assign code_char = fifo_out_data[vfd_port_pkg::DATA_W-1:0];
  assign parallel_data_pins_out = out_reg;
  assign parallel_data_pins_oe_n = oe_n_reg;
  assign bus_width_8 = width8_reg;
  assign two_line_mode = two_line_reg;
endmodule : vfd_host_port

// *** dv/vfd_host_port_properties.sv ***
`timescale 1ns/1ps
module vfd_host_port_checker #(
  parameter int DIGIT_COUNT = 24,
  parameter int CODE_FIFO_DEPTH = 32
) (
  // clock, reset and straps
  input wire logic clock,
  input wire logic rst_n,
  input wire logic link_style_select,
  input wire logic host_bus_style_select,
  // host strobes
  input wire logic chip_select_n,
  input wire logic register_select_line,
  input wire logic enable_or_read_n,
  input wire logic rw_or_write_n,
  // data pins
  input wire logic [7:0] parallel_data_pins_out,
  input wire logic [7:0] parallel_data_pins_oe_n,
  // code stream and mode
  input wire logic code_valid,
  input wire logic code_ready,
  input wire logic [7:0] code_char,
  input wire logic [4:0] code_position,
  input wire logic code_line,
  input wire logic bus_width_8,
  input wire logic two_line_mode
);
  logic act_q;
  wire act = link_style_select & !chip_select_n &
    (host_bus_style_select ? enable_or_read_n : (!enable_or_read_n | !rw_or_write_n));
  wire is_read = host_bus_style_select ? rw_or_write_n : !enable_or_read_n;
  wire start = act & !act_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      act_q <= 1'b0;
    end else begin
      act_q <= act;
    end
  end
  // nibble phase: the second nibble of a status read carries address bit 3 on pin 7
  logic nib_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nib_q <= 1'b0;
    end else if (bus_width_8) begin
      nib_q <= 1'b0;
    end else if (act_q && !act) begin
      nib_q <= !nib_q;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_status_busy_low: assert property (start && is_read && !register_select_line
    && (bus_width_8 || !nib_q) |-> ##1 !parallel_data_pins_out[7])
    else $error("busy bit read high");
  chk_read_drives_pins: assert property (start && is_read
    |-> ##1 parallel_data_pins_oe_n == (bus_width_8 ? 8'h00 : 8'h0F))
    else $error("read not driving pins");
  chk_write_no_drive: assert property (start && !is_read
    |-> ##2 parallel_data_pins_oe_n == 8'hFF) else $error("pins driven on write");
  chk_idle_pins_released: assert property (!$past(act)
    |-> parallel_data_pins_oe_n == 8'hFF) else $error("pins driven while idle");
  chk_nibble_low_zero: assert property (!bus_width_8 && !parallel_data_pins_oe_n[7]
    |-> parallel_data_pins_out[3:0] == 4'h0) else $error("low nibble not zero");
  chk_code_held: assert property (code_valid && !code_ready
    |=> code_valid && $stable(code_char) && $stable(code_position))
    else $error("code changed before pop");
  chk_mode_at_commit: assert property ($changed(two_line_mode) || $changed(bus_width_8)
    |-> $past(act_q && !act && !register_select_line)) else $error("mode changed off commit");
  chk_position_order: assert property (code_valid && code_ready
    && int'(code_position) < DIGIT_COUNT - 1
    |=> !code_valid || code_position == $past(code_position) + 5'h01)
    else $error("position order broken");
  cover property (start && is_read && register_select_line && !bus_width_8);
  cover property (code_valid && code_ready && code_line);
  cover property ($rose(two_line_mode));
endmodule : vfd_host_port_checker

bind vfd_host_port vfd_host_port_checker #(
  .DIGIT_COUNT(DIGIT_COUNT),
  .CODE_FIFO_DEPTH(CODE_FIFO_DEPTH)
) chk_i (.clock(clock), .rst_n(rst_n), .link_style_select(link_style_select),
  .host_bus_style_select(host_bus_style_select), .chip_select_n(chip_select_n),
  .register_select_line(register_select_line), .enable_or_read_n(enable_or_read_n),
  .rw_or_write_n(rw_or_write_n), .parallel_data_pins_out(parallel_data_pins_out),
  .parallel_data_pins_oe_n(parallel_data_pins_oe_n), .code_valid(code_valid),
  .code_ready(code_ready), .code_char(code_char), .code_position(code_position),
  .code_line(code_line), .bus_width_8(bus_width_8), .two_line_mode(two_line_mode));

// *** dv/host_cpu_model.sv ***
`timescale 1ns/1ps
module host_cpu_model (
  // clock and straps
  input wire logic clock,
  input wire logic wide,
  input wire logic style_68,
  // strobes
  output logic cs_n,
  output logic reg_sel,
  output logic strobe_a,
  output logic strobe_b,
  // data pins
  input wire logic [7:0] pins,
  output logic [7:0] drive,
  // read results
  output logic done,
  output logic [7:0] rbyte
);
  initial begin
    cs_n = 1'b1;
    reg_sel = 1'b0;
    strobe_a = 1'b1;
    strobe_b = 1'b1;
    drive = 8'h00;
    done = 1'b0;
    rbyte = 8'h00;
  end
  // strobe held three edges so the answer has settled before it is taken
  task automatic xfer(input logic rs, input logic rd, input logic [7:0] wd,
                      output logic [7:0] q);
    @(posedge clock);
    cs_n <= 1'b0;
    reg_sel <= rs;
    strobe_a <= style_68 | !rd;
    strobe_b <= rd;
    drive <= wd;
    repeat (3) @(posedge clock);
    q = pins;
    cs_n <= 1'b1;
    strobe_a <= !style_68;
    strobe_b <= 1'b1;
    drive <= ~wd;
    repeat (2) @(posedge clock);
  endtask : xfer
  task automatic access(input logic rs, input logic rd, input logic [7:0] wd);
    logic [7:0] hi;
    logic [7:0] lo;
    if (wide) begin
      xfer(rs, rd, wd, lo);
    end else begin
      xfer(rs, rd, {wd[7:4], 4'h0}, hi);
      xfer(rs, rd, {wd[3:0], 4'h0}, lo);
      lo = {hi[7:4], lo[7:4]};
    end
    if (rd) begin
      rbyte <= lo;
      done <= 1'b1;
      @(posedge clock);
      done <= 1'b0;
    end
  endtask : access
endmodule : host_cpu_model

// *** dv/vfd_host_port_and_text_ram_test.sv ***
`timescale 1ns/1ps
module vfd_host_port_and_text_ram_test;
  logic clock;
  logic rst_n;
  logic link_style_select;
  logic host_bus_style_select;
  logic wide;
  logic code_ready;
  logic watch;
  logic two_ln;
  logic [7:0] seed;
  logic [7:0] text_mem [80];
  logic [7:0] exp_q [$];
  int offset;
  int miscompares;
  int compares;
  wire cs_n, rs, sa, sb, done, code_valid, code_line, bus_width_8, two_line_mode;
  wire [7:0] drive, rbyte, pins_out, oe_n, code_char;
  wire [4:0] code_position;
  wire [7:0] pins = (oe_n & drive) | (~oe_n & pins_out);
  vfd_host_port uut (.clock(clock), .rst_n(rst_n), .link_style_select(link_style_select),
    .host_bus_style_select(host_bus_style_select), .chip_select_n(cs_n),
    .register_select_line(rs), .enable_or_read_n(sa), .rw_or_write_n(sb),
    .parallel_data_pins_in(pins), .parallel_data_pins_out(pins_out),
    .parallel_data_pins_oe_n(oe_n), .code_valid(code_valid), .code_ready(code_ready),
    .code_char(code_char), .code_position(code_position), .code_line(code_line),
    .bus_width_8(bus_width_8), .two_line_mode(two_line_mode));
  host_cpu_model host (.clock(clock), .wide(wide), .style_68(host_bus_style_select),
    .cs_n(cs_n), .reg_sel(rs), .strobe_a(sa), .strobe_b(sb), .pins(pins),
    .drive(drive), .done(done), .rbyte(rbyte));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic int code_index(input logic [4:0] p, input logic l);
    if (two_ln) return (l ? 40 : 0) + (int'(p) + offset) % 40;
    return (int'(p) + offset) % 80;
  endfunction : code_index
  task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : compare
  task automatic compare_mode(input string what, input logic exp, input logic got);
    compare(what, {7'h00, exp}, {7'h00, got});
  endtask : compare_mode
  task automatic compare_code(input logic [7:0] exp, input logic [7:0] got);
    compare("code", exp, got);
  endtask : compare_code
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic instr(input logic [7:0] code);
    host.access(1'b0, 1'b0, code);
  endtask : instr
  task automatic read(input logic sel, input logic [7:0] exp);
    exp_q.push_back(exp);
    host.access(sel, 1'b1, 8'h00);
  endtask : read
  // stale queue entries drain in the quiet half before checking starts
  task automatic observe();
    watch <= 1'b0;
    repeat (150) @(posedge clock);
    watch <= 1'b1;
    repeat (150) @(posedge clock);
    watch <= 1'b0;
  endtask : observe
  always @(posedge clock) begin
    seed <= lfsr(seed);
    code_ready <= seed[0];
    if (done) begin
      compare("read data", (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx, rbyte);
    end
    if (watch && code_valid === 1'b1 && code_ready) begin
      compare_code(text_mem[code_index(code_position, code_line)], code_char);
    end
  end
  initial begin
    repeat (100000) @(posedge clock);
    $display("ERROR watchdog expected end seen hang");
    miscompares++;
    give_verdict();
  end
  initial begin
    rst_n = 1'b0;
    link_style_select = 1'b1;
    host_bus_style_select = 1'b0;
    wide = 1'b1;
    watch = 1'b0;
    two_ln = 1'b0;
    seed = 8'h17;
    code_ready = 1'b0;
    offset = 0;
    miscompares = 0;
    compares = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    compare_mode("width reset", 1'b1, bus_width_8);
    compare_mode("lines reset", 1'b0, two_line_mode);
    repeat (3) @(posedge clock);
    instr(8'h80);
    for (int a = 0; a < 80; a++) begin
      text_mem[a] = seed;
      host.access(1'b1, 1'b0, seed);
    end
    read(1'b0, 8'h00);
    instr(8'hCE);
    read(1'b1, text_mem[78]);
    read(1'b1, text_mem[79]);
    read(1'b1, text_mem[0]);
    read(1'b0, 8'h01);
    observe();
    instr(8'h18);
    offset = 1;
    observe();
    instr(8'h1C);
    instr(8'h1C);
    offset = 79;
    observe();
    instr(8'h38);
    two_ln = 1'b1;
    compare_mode("lines", 1'b1, two_line_mode);
    observe();
    instr(8'h02);
    offset = 0;
    instr(8'hA7);
    text_mem[39] = 8'h5A;
    host.access(1'b1, 1'b0, 8'h5A);
    read(1'b0, 8'h40);
    host_bus_style_select <= 1'b1;
    instr(8'h28);
    wide = 1'b0;
    compare_mode("width", 1'b0, bus_width_8);
    instr(8'hC1);
    text_mem[41] = 8'hC3;
    host.access(1'b1, 1'b0, 8'hC3);
    instr(8'hC1);
    read(1'b1, 8'hC3);
    read(1'b0, 8'h42);
    link_style_select <= 1'b0;
    instr(8'h80);
    link_style_select <= 1'b1;
    read(1'b0, 8'h42);
    instr(8'h40);
    for (int g = 0; g < 3; g++) begin
      host.access(1'b1, 1'b0, 8'h11 + 8'(g));
    end
    read(1'b0, 8'h03);
    instr(8'h40);
    read(1'b1, 8'h11);
    observe();
    repeat (4) @(posedge clock);
    if (exp_q.size() != 0) begin
      $display("ERROR read queue expected 0 seen %0d", exp_q.size());
      miscompares++;
    end
    give_verdict();
  end
endmodule : vfd_host_port_and_text_ram_test
